//--- pkg/ddr_io_pkg.sv
// Shared constants, types and pin-mapping functions for the DDR memory I/O datapath.
// Assumes one 100 MHz system clock and one memory clock cycle per four system cycles.
package ddr_io_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int GROUP_PINS  = 9;    // Data pins per strobe group at most.
  localparam int BYTE_BITS   = 8;    // Data bits covered by one parity bit.
  localparam int NUM_GROUPS  = 2;    // Groups of the widest mode (x16/x18).
  localparam int CMD_W       = 4;    // Chip select, row strobe, column strobe, write enable.
  localparam int ADDR_W      = 14;
  localparam int DLY_TAPS    = 8;    // Steps of the read strobe delay line.
  localparam int DLY_W       = 3;

  // ---------------------------------------------------------------------------
  // Reset values, idle codes and limits
  // ---------------------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_NOP = 4'h7;   // Selected, no operation.
  localparam logic [3:0]       PAR_POS_MAX = 4'h8;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int SYS_CLK_MHZ  = 100;
  localparam int MEM_CLK_MHZ  = 25;
  localparam int SYS_PER_MEM  = SYS_CLK_MHZ / MEM_CLK_MHZ;   // Four quarter phases.
  localparam int ECHO_GUARD   = DLY_TAPS + 4;   // Cycles a released write strobe may still echo in the delay line.

  // Quarter phases of the memory clock, named by system clock and write clock levels.
  typedef enum logic [1:0] {
    PH_S1W1 = 2'h0,
    PH_S1W0 = 2'h1,
    PH_S0W0 = 2'h3,
    PH_S0W1 = 2'h2
  } phase_type;

  // Data group width modes; bit 1 selects two groups, bit 0 the ninth pin.
  typedef enum logic [1:0] {
    MODE_X8  = 2'h0,
    MODE_X9  = 2'h1,
    MODE_X18 = 2'h3,
    MODE_X16 = 2'h2
  } width_mode_type;

  // Places even parity of a byte on pin pos and the data bits on the others.
  function automatic logic [GROUP_PINS-1:0] parity_insert(input logic [BYTE_BITS-1:0] d,
                                                          input logic [3:0]           pos);
    logic [GROUP_PINS-1:0] r;
    logic [3:0]            p;
    logic [3:0]            k;
    r = '0;
    k = 4'h0;
    p = (pos > PAR_POS_MAX) ? PAR_POS_MAX : pos;
    for (int i = 0; i < GROUP_PINS; i++) begin
      if (4'(i) == p) begin
        r[i] = ^d;
      end else begin
        r[i] = d[k[2:0]];
        k    = k + 4'h1;
      end
    end
    return r;
  endfunction

  // Gathers the data byte back from the pins, skipping the parity pin.
  function automatic logic [BYTE_BITS-1:0] parity_extract(input logic [GROUP_PINS-1:0] w,
                                                          input logic [3:0]            pos);
    logic [BYTE_BITS-1:0] r;
    logic [3:0]           p;
    logic [3:0]           k;
    r = '0;
    k = 4'h0;
    p = (pos > PAR_POS_MAX) ? PAR_POS_MAX : pos;
    for (int i = 0; i < GROUP_PINS; i++) begin
      if (4'(i) != p) begin
        r[k[2:0]] = w[i];
        k         = k + 4'h1;
      end
    end
    return r;
  endfunction

endpackage

//--- design/strobe_delay.sv
// Synchroniser, programmable delay line and edge finder for one incoming read strobe.
// Assumes the strobe is asynchronous to sys_clk and much slower than it.
`timescale 1ns/1ps
module strobe_delay
  import ddr_io_pkg::*;
#(
  parameter int TAPS = DLY_TAPS,
  parameter int SW   = DLY_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          strobeIn,
  input  wire logic [SW-1:0] delaySel,
  output logic               riseP,
  output logic               fallP
);

  logic            sync1_q;
  logic            sync2_q;
  logic [TAPS-1:0] hist_q;
  logic            dly_q;
  logic            tap;

  // ---------------------------------------------------------------------------
  // Two-stage synchroniser feeding the delay line.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= strobeIn;
      sync2_q <= sync1_q;
    end
  end

  // Shift history of the strobe; the tap picks how far it is pushed back.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[TAPS-2:0], sync2_q};
    end
  end

  assign tap = hist_q[delaySel];  // RULE3

  // Edge pulses of the delayed strobe, one cycle each.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_q <= 1'b0;
      riseP <= 1'b0;
      fallP <= 1'b0;
    end else begin
      dly_q <= tap;
      riseP <= tap & ~dly_q;
      fallP <= ~tap & dly_q;
    end
  end

  AST_DELAY_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE3
    (delaySel == '0 && $stable(delaySel) && hist_q[0] && !dly_q) |=> riseP)
    else $error("Undelayed strobe edge gave no rise pulse.");

endmodule // strobe_delay

//--- design/ddr_memory_io_datapath.sv
// Top of the DDR/DDR2 memory I/O datapath: write launch, command launch and read capture.
// Assumes a user controller issues commands and data; memory pins run through board buffers.
//
// Function
// RULE1: A group is one strobe, one mask and up to nine data pins.
// RULE2: Read timing comes from a two-way strobe or a one-way read clock.
// RULE3: Each incoming strobe is delayed by a programmable amount to centre it.
// RULE4: The delayed strobe is shared to clock all capture registers of its group.
// RULE5: Groups run as x8/x9 or x16/x18; x9 also serves x8, x18 x16.
// RULE6: One parity bit per eight data bits, placeable on any data pin.
// RULE7: Mask driven low for written bytes, high for masked ones; memory ignores masked.
// RULE8: Every group has its own mask output, driven on every write.
// RULE9: System and write clocks come from one two-output clock source.
// RULE10: Write strobes, commands and addresses launch on the system clock.
// RULE11: Write data launch on the write clock, 90 degrees ahead of system clock.
// RULE12: Read data captured on both strobe edges, two words per strobe cycle.
`timescale 1ns/1ps
module ddr_memory_io_datapath
  import ddr_io_pkg::*;
#(
  parameter int NG = NUM_GROUPS,
  parameter int AW = ADDR_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic [1:0]            widthMode,
  input  wire logic                  parityEn,
  input  wire logic [3:0]            parityPos,
  input  wire logic                  readClkSel,
  input  wire logic [DLY_W-1:0]      strobeDelay,
  input  wire logic                  cmdValid,
  input  wire logic [CMD_W-1:0]      cmdCode,
  input  wire logic [AW-1:0]         cmdAddr,
  output logic                       cmdReady,
  input  wire logic                  wrValid,
  input  wire logic [NG*9-1:0]       wrDataRise,
  input  wire logic [NG*9-1:0]       wrDataFall,
  input  wire logic [NG-1:0]         wrEnRise,
  input  wire logic [NG-1:0]         wrEnFall,
  output logic                       wrReady,
  output logic [NG-1:0]              rdValid,
  output logic [NG*9-1:0]            rdDataRise,
  output logic [NG*9-1:0]            rdDataFall,
  output logic [NG-1:0]              rdParErr,
  output logic                       memClk,
  output logic [CMD_W-1:0]           memCmd,
  output logic [AW-1:0]              memAddr,
  output logic [NG*9-1:0]            dqOut,
  output logic [NG*9-1:0]            dqOe_b,
  input  wire logic [NG*9-1:0]       dqIn,
  output logic [NG-1:0]              dmOut,
  output logic [NG-1:0]              dqsOut,
  output logic [NG-1:0]              dqsOe_b,
  input  wire logic [NG-1:0]         dqsIn,
  input  wire logic [NG-1:0]         rdClkIn
);

  phase_type          ph_q;
  logic               writeAct_q;
  logic [NG*9-1:0]    fallHold_q;
  logic [NG-1:0]      enFallHold_q;
  logic [NG*9-1:0]    dqSync1_q;
  logic [NG*9-1:0]    dqSync2_q;
  logic [NG*9-1:0]    riseCap_q;
  logic [NG-1:0]      dqsRise, dqsFall, rckRise, rckFall, capRise, capFall, grpOn;
  logic [NG*9-1:0]    wordRise, wordFall;
  logic [NG*9-1:0]    pinOn;
  logic               wrTake;
  logic               cmdTake;
  logic [3:0]         echoGuard_q;

  // ---------------------------------------------------------------------------
  // Clock phases
  // ---------------------------------------------------------------------------
  // Quarter-phase walker: one source gives both the system and the write clock.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q <= PH_S1W1;
    end else begin
      case (ph_q)  // RULE9
        PH_S1W1: ph_q <= PH_S1W0;
        PH_S1W0: ph_q <= PH_S0W0;
        PH_S0W0: ph_q <= PH_S0W1;
        PH_S0W1: ph_q <= PH_S1W1;
        default: ph_q <= PH_S1W1;
      endcase
    end
  end

  // Memory clock follows the system clock level of the phase being entered.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memClk <= 1'b0;
    end else if (ph_q == PH_S0W1) begin
      memClk <= 1'b1;  // RULE10
    end else if (ph_q == PH_S1W0) begin
      memClk <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------------------
  assign cmdTake = cmdValid && cmdReady;

  // Ready marks the quarter before the system clock rise.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdReady <= 1'b0;
    end else begin
      cmdReady <= (ph_q == PH_S0W0);
    end
  end

  // Command and address change only on the system clock rising edge.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memCmd  <= CMD_NOP;
      memAddr <= '0;
    end else if (ph_q == PH_S0W1) begin
      memCmd <= cmdTake ? cmdCode : CMD_NOP;  // RULE10
      if (cmdTake) begin
        memAddr <= cmdAddr;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------------------
  assign wrTake = wrValid && wrReady;

  // Pin words per group: width mode decides the ninth pin, parity may take any pin.
  always_comb begin
    for (int g = 0; g < NG; g++) begin
      for (int i = 0; i < GROUP_PINS; i++) begin
        pinOn[g*9+i] = ((g == 0) || widthMode[1]) && ((i < BYTE_BITS) || widthMode[0]);  // RULE5 RULE1
      end
      if (parityEn && widthMode[0]) begin
        wordRise[g*9 +: 9] = parity_insert(wrDataRise[g*9 +: 8], parityPos);  // RULE6
        wordFall[g*9 +: 9] = parity_insert(wrDataFall[g*9 +: 8], parityPos);
      end else begin
        wordRise[g*9 +: 9] = wrDataRise[g*9 +: 9];
        wordFall[g*9 +: 9] = wrDataFall[g*9 +: 9];
      end
    end
  end

  // Ready marks the quarter before the write clock rise.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrReady <= 1'b0;
    end else begin
      wrReady <= (ph_q == PH_S1W0);
    end
  end

  // Data and mask launch on write clock edges, a quarter ahead of the strobe.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      writeAct_q   <= 1'b0;
      dqOut        <= '0;
      dqOe_b       <= '1;
      dmOut        <= '1;
      fallHold_q   <= '0;
      enFallHold_q <= '0;
    end else if (ph_q == PH_S0W0) begin
      writeAct_q <= wrTake;
      if (wrTake) begin
        dqOut        <= wordRise & pinOn;  // RULE11
        dqOe_b       <= ~pinOn;
        dmOut        <= ~(wrEnRise & {{(NG-1){widthMode[1]}}, 1'b1});  // RULE7 RULE8
        fallHold_q   <= wordFall & pinOn;
        enFallHold_q <= wrEnFall & {{(NG-1){widthMode[1]}}, 1'b1};
      end else begin
        dqOe_b <= '1;
        dmOut  <= '1;
      end
    end else if (ph_q == PH_S1W1 && writeAct_q) begin
      dqOut <= fallHold_q;  // RULE11
      dmOut <= ~enFallHold_q;  // RULE7 RULE8
    end
  end

  // Write strobes toggle on the system clock while a beat is on the pins.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dqsOut  <= '0;
      dqsOe_b <= '1;
    end else if (ph_q == PH_S0W0) begin
      dqsOe_b <= wrTake ? ~{{(NG-1){widthMode[1]}}, 1'b1} : '1;
    end else if (ph_q == PH_S0W1) begin
      dqsOut <= writeAct_q ? ~dqsOe_b : '0;  // RULE10
    end else if (ph_q == PH_S1W0) begin
      dqsOut <= '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Read data pins pass two flip-flops before capture.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dqSync1_q <= '0;
      dqSync2_q <= '0;
    end else begin
      dqSync1_q <= dqIn;
      dqSync2_q <= dqSync1_q;
    end
  end

  // One delay line per group for each strobe source.
  for (genvar g = 0; g < NG; g++) begin : gGrp
    strobe_delay #(.TAPS(DLY_TAPS), .SW(DLY_W)) uDqs (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .strobeIn (dqsIn[g]),
      .delaySel (strobeDelay),
      .riseP    (dqsRise[g]),
      .fallP    (dqsFall[g])
    );
    strobe_delay #(.TAPS(DLY_TAPS), .SW(DLY_W)) uRck (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .strobeIn (rdClkIn[g]),
      .delaySel (strobeDelay),
      .riseP    (rckRise[g]),
      .fallP    (rckFall[g])
    );
  end

  // Capture enables from the chosen strobe, shared by every pin of an enabled group.
  assign grpOn   = {{(NG-1){widthMode[1]}}, 1'b1};  // RULE5
  assign capRise = (readClkSel ? rckRise : (dqsRise & dqsOe_b & {NG{echoGuard_q == 4'h0}})) & grpOn;  // RULE2 RULE4
  assign capFall = (readClkSel ? rckFall : (dqsFall & dqsOe_b & {NG{echoGuard_q == 4'h0}})) & grpOn;  // RULE2 RULE4

  // Rise word held; fall edge completes the pair and presents both words.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      riseCap_q  <= '0;
      echoGuard_q <= 4'h0;
      rdDataRise <= '0;
      rdDataFall <= '0;
      rdValid    <= '0;
      rdParErr   <= '0;
    end else begin
      // Own write strobes loop back on dqsIn; capture waits until their echo has left the delay line.
      echoGuard_q <= (dqsOe_b != '1) ? 4'(ECHO_GUARD) : echoGuard_q - {3'h0, echoGuard_q != 4'h0};  // RULE4
      for (int g = 0; g < NG; g++) begin
        rdValid[g]  <= capFall[g];  // RULE12
        rdParErr[g] <= 1'b0;
        if (capRise[g]) begin
          riseCap_q[g*9 +: 9] <= dqSync2_q[g*9 +: 9];  // RULE4 RULE12
        end
        if (capFall[g]) begin
          if (parityEn && widthMode[0]) begin
            rdDataRise[g*9 +: 9] <= {1'b0, parity_extract(riseCap_q[g*9 +: 9], parityPos)};  // RULE6
            rdDataFall[g*9 +: 9] <= {1'b0, parity_extract(dqSync2_q[g*9 +: 9], parityPos)};
            rdParErr[g]          <= (^riseCap_q[g*9 +: 9]) | (^dqSync2_q[g*9 +: 9]);
          end else begin
            rdDataRise[g*9 +: 9] <= riseCap_q[g*9 +: 9];
            rdDataFall[g*9 +: 9] <= dqSync2_q[g*9 +: 9];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_CLK_RISE: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE9
    (ph_q == PH_S0W1) |=> memClk ##2 !memClk)
    else $error("Memory clock rise or fall out of phase.");
  AST_CMD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE10
    (ph_q == PH_S0W1 && !cmdTake) |=> (memCmd == CMD_NOP) [*4])
    else $error("Command not idle without a request.");
  AST_DATA_LEADS: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE11
    wrTake |=> !dqsOe_b[0] && !dqsOut[0] ##1 dqsOut[0] ##1 dqOut == $past(fallHold_q))
    else $error("Write data does not lead the strobe by a quarter.");
  AST_MASK_RISE: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE7
    wrTake |=> dmOut[0] == !$past(wrEnRise[0]))
    else $error("Mask level wrong for the rise beat.");
  AST_MASK_FALL: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE8
    wrTake ##2 1'b1 |=> dmOut[0] == !$past(wrEnFall[0], 3))
    else $error("Mask level wrong for the fall beat.");
  AST_NINTH_PIN: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE5
    (wrTake && !widthMode[0]) |=> dqOe_b[8] && !dqOe_b[7])
    else $error("Ninth pin driven in an eight-bit mode.");
  AST_PARITY_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE6
    (wrTake && parityEn && widthMode[0]) |=> (^dqOut[8:0]) == 1'b0)
    else $error("Write parity is not even.");
  AST_READ_PAIR: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE12
    capFall[0] |=> rdValid[0] ##1 !rdValid[0])
    else $error("Read pair not presented for one cycle.");

endmodule // ddr_memory_io_datapath

//--- sim/ddr_mem_model.sv
// Partner model: a DDR memory seen at the pins of the I/O datapath.
// Assumes two groups of nine data pins and a 100 MHz clock to sample the write strobe.
`timescale 1ns/1ps
module ddr_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        readClkSel,
  input  wire logic [17:0] dqOut,
  input  wire logic [17:0] dqOe_b,
  input  wire logic [1:0]  dmOut,
  input  wire logic [1:0]  dqsOut,
  input  wire logic [1:0]  dqsOe_b,
  output logic [17:0]      dqIn,
  output logic [1:0]       dqsIn,
  output logic [1:0]       rdClkIn
);
  logic [17:0] drvDq   = 18'h00000;
  logic [1:0]  drvStb  = 2'h0;
  logic [1:0]  stbQ    = 2'h0;
  logic [17:0] memRise = 18'h00000;
  logic [17:0] memFall = 18'h00000;

  // Each wire takes the level of whichever party drives it; an idle strobe is pulled low.
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      dqIn[i] = dqOe_b[i] ? drvDq[i] : dqOut[i];
    end
    for (int g = 0; g < 2; g++) begin
      dqsIn[g]   = dqsOe_b[g] ? (drvStb[g] & ~readClkSel) : dqsOut[g];
      rdClkIn[g] = drvStb[g] & readClkSel;
    end
  end

  // Stores a lane on each write strobe edge, but only while its mask is low.
  always @(posedge sys_clk) begin
    stbQ <= dqsOut;
    for (int g = 0; g < 2; g++) begin
      if (!dqsOe_b[g] && dmOut[g] === 1'h0) begin
        if (dqsOut[g] && !stbQ[g]) memRise[g*9+:9] <= dqOut[g*9+:9];
        if (!dqsOut[g] && stbQ[g]) memFall[g*9+:9] <= dqOut[g*9+:9];
      end
    end
  end

  // Sends one read beat with strobe edges on the data edges, then drives the inverse of the fall word.
  task automatic read_burst(input logic [17:0] r, input logic [17:0] f);
    #3.7;
    drvDq = r;
    drvStb = 2'h3;
    #40;
    drvDq = f;
    drvStb = 2'h0;
    #40;
    drvDq = ~f;
  endtask
endmodule // ddr_mem_model

//--- sim/tb_ddr_memory_io_datapath.sv
// Self-checking bench for the DDR memory I/O datapath: random beats with corner cases.
// Assumes the memory model ddr_mem_model and the design's default two-group geometry.
`timescale 1ns/1ps
module tb_ddr_memory_io_datapath
  import ddr_io_pkg::*;
;
  logic             sys_clk, rst_b, parityEn, readClkSel, cmdValid, wrValid, cmdReady, wrReady, memClk;
  logic [1:0]       widthMode, wrEnRise, wrEnFall, rdValid, rdParErr, dmOut, dqsOut, dqsOe_b, dqsIn, rdClkIn;
  logic [3:0]       parityPos, cmdCode, memCmd;
  logic [DLY_W-1:0] strobeDelay;
  logic [13:0]      cmdAddr, memAddr;
  logic [17:0]      wrDataRise, wrDataFall, rdDataRise, rdDataFall, dqOut, dqOe_b, dqIn, pr, pf;
  int               miscompares, checks_done;

  ddr_memory_io_datapath i_ddr_memory_io_datapath (
    .sys_clk, .rst_b, .widthMode, .parityEn, .parityPos, .readClkSel, .strobeDelay, .cmdValid,
    .cmdCode, .cmdAddr, .cmdReady, .wrValid, .wrDataRise, .wrDataFall, .wrEnRise, .wrEnFall,
    .wrReady, .rdValid, .rdDataRise, .rdDataFall, .rdParErr, .memClk, .memCmd, .memAddr,
    .dqOut, .dqOe_b, .dqIn, .dmOut, .dqsOut, .dqsOe_b, .dqsIn, .rdClkIn
  );
  ddr_mem_model i_ddr_mem_model (
    .sys_clk, .readClkSel, .dqOut, .dqOe_b, .dmOut, .dqsOut, .dqsOe_b, .dqIn, .dqsIn, .rdClkIn
  );

  // Free-running 100 MHz system clock.
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Steps whole cycles and lands just after the edge, where outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Compares one value and counts it.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A handshake that never came counts as a fault and ends the run.
  task automatic give_up();
    miscompares++;
    $display("timeout at %0t", $time);
    end_sim();
  endtask

  // Pins in use for the width mode, and groups in use.
  function automatic logic [17:0] pin_mask();
    return {widthMode[1] ? {widthMode[0], 8'hFF} : 9'h000, widthMode[0], 8'hFF};
  endfunction
  function automatic logic [1:0] grp_mask();
    return {widthMode[1], 1'h1};
  endfunction
  function automatic int ppos();
    return (parityPos > 4'h8) ? 8 : int'(parityPos);
  endfunction

  // Spreads a byte over nine pins with even parity on the chosen pin.
  function automatic logic [8:0] ins(input logic [7:0] d);
    logic [8:0] r;
    int         k;
    k = 0;
    for (int i = 0; i < 9; i++) begin
      if (i == ppos()) r[i] = ^d;
      else begin
        r[i] = d[k];
        k++;
      end
    end
    return r;
  endfunction

  // Expected pin word for a user write word in the current mode.
  function automatic logic [17:0] exp_wr(input logic [17:0] w);
    logic [17:0] e;
    for (int g = 0; g < 2; g++) begin
      e[g*9+:9] = (parityEn && widthMode[0]) ? ins(w[g*9+:8]) : w[g*9+:9];
    end
    return e & pin_mask();
  endfunction

  // Idle pins: no operation, data and strobes released, every mask high.
  task automatic chk_idle();
    cmp({memCmd, dmOut, dqsOe_b, dqOe_b}, {CMD_NOP, 2'h3, 2'h3, 18'h3FFFF});
  endtask

  // Issues one command, with a write beat when doWr is set, and follows the pins.
  task automatic xfer(input logic doWr);
    logic [17:0] pm;
    logic [1:0]  gm;
    logic        mc;
    int          n;
    pm = pin_mask();
    gm = grp_mask();
    cmdCode = 4'($urandom);
    cmdAddr = 14'($urandom);
    cmdValid = 1'h1;
    wrValid = doWr;
    // Write beats are taken one quarter before the command quarter, so wait for wrReady.
    for (n = 0; n < 9 && wrReady !== 1'h1; n++) tick(1);
    if (n == 9) give_up();
    tick(1);
    wrValid = 1'h0;
    cmp(cmdReady, 1'h1);
    tick(1);
    cmdValid = 1'h0;
    mc = memClk;
    cmp({memCmd, memAddr}, {cmdCode, cmdAddr});
    if (doWr) begin
      cmp(dqOut & pm, exp_wr(wrDataRise));
      cmp({dqOe_b, dqsOe_b, dqsOut}, {~pm, ~gm, gm});
      cmp(2'(~(wrEnRise & gm)), dmOut);
    end else cmp({dqOe_b, dqsOe_b}, {18'h3FFFF, 2'h3});
    tick(1);
    if (doWr) cmp(dqsOut, gm);
    tick(1);
    cmp(memClk, 1'(~mc));
    if (doWr) begin
      cmp(dqOut & pm, exp_wr(wrDataFall));
      cmp(2'(~(wrEnFall & gm)), dmOut);
    end
  endtask

  // Model contents after a beat: written lanes replaced, masked lanes kept.
  task automatic chk_mem(input logic [17:0] pr0, input logic [17:0] pf0);
    logic [17:0] er, ef, pm;
    pm = pin_mask();
    er = exp_wr(wrDataRise);
    ef = exp_wr(wrDataFall);
    for (int g = 0; g < 2; g++) begin
      if (!wrEnRise[g]) er[g*9+:9] = pr0[g*9+:9];
      if (!wrEnFall[g]) ef[g*9+:9] = pf0[g*9+:9];
    end
    cmp(i_ddr_mem_model.memRise & pm, er & pm);
    cmp(i_ddr_mem_model.memFall & pm, ef & pm);
  endtask

  // Sends one read beat through the model, with a parity fault at random.
  task automatic rd_test();
    logic [17:0] r, f, er, ef, pm;
    logic [1:0]  ee;
    logic        fl;
    int          n;
    pm = pin_mask();
    ee = 2'h0;
    r = 18'($urandom);
    f = 18'($urandom);
    er = r;
    ef = f;
    for (int g = 0; g < 2; g++) begin
      if (parityEn && widthMode[0]) begin
        er[g*9+:9] = {1'h0, r[g*9+:8]};
        ef[g*9+:9] = {1'h0, f[g*9+:8]};
        fl = 1'($urandom);
        r[g*9+:9] = ins(r[g*9+:8]) ^ (9'(fl) << ppos());
        f[g*9+:9] = ins(f[g*9+:8]);
        ee[g] = fl & (g == 0 || widthMode[1]);
      end
    end
    fork
      i_ddr_mem_model.read_burst(r, f);
      begin
        for (n = 0; n < 30 && rdValid === 2'h0; n++) tick(1);
        if (n == 30) give_up();
        cmp({rdValid, rdParErr}, {grp_mask(), ee});
        cmp(rdDataRise & pm, er & pm);
        cmp(rdDataFall & pm, ef & pm);
      end
    join
  endtask

  // Reset, then random tests over every width mode, then the verdict.
  initial begin
    {rst_b, parityEn, readClkSel, cmdValid, wrValid, cmdCode, cmdAddr} = '0;
    {widthMode, parityPos, wrEnRise, wrEnFall, wrDataRise, wrDataFall} = '0;
    strobeDelay = 3'h1;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(32'h7E4CFCFF));
    tick(5);
    chk_idle();
    rst_b = 1'h1;
    for (int i = 0; i < 24; i++) begin
      widthMode = 2'(i);
      parityEn = (i < 8) | 1'($urandom);
      parityPos = (i % 5 == 0) ? 4'hF : 4'($urandom % 9);
      readClkSel = 1'($urandom);
      // Sync and capture stages use most of a half link period; only 0 or 1 extra taps stay in the window.
      strobeDelay = (i % 4 == 0) ? 3'h0 : 3'($urandom % 2);
      wrDataRise = 18'($urandom);
      wrDataFall = 18'($urandom);
      wrEnRise = (i % 6 == 1) ? 2'h0 : 2'($urandom);
      wrEnFall = (i % 6 == 3) ? 2'h3 : 2'($urandom);
      pr = i_ddr_mem_model.memRise;
      pf = i_ddr_mem_model.memFall;
      xfer(1'h1);
      xfer(1'(i % 2));
      // Lets the echo of the last write strobe clear the read guard before the read beat.
      tick(10);
      chk_idle();
      if (i % 2 == 0) chk_mem(pr, pf);
      rd_test();
      tick(4);
      if (i == 12) begin
        rst_b = 1'h0;
        tick(2);
        chk_idle();
        rst_b = 1'h1;
      end
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule // tb_ddr_memory_io_datapath
